// ===== design/hfsc_pkg.sv
// Shared constants for the Hall-commutated fan speed controller
package hfsc_pkg;
  // System clock rate
  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned CYC_PER_MS      = CLK_HZ / 1000;
  localparam int unsigned CYC_PER_US      = CLK_HZ / 1_000_000;
  // Width of the long timers
  localparam int unsigned CNT_W           = 24;
  // Width of temperature and speed codes
  localparam int unsigned CODE_W          = 8;
  // Locked-rotor window
  localparam int unsigned LOCK_TIME_MS    = 100;
  localparam int unsigned LOCK_CYC        = LOCK_TIME_MS * CYC_PER_MS;
  // Full-power start-up period
  localparam int unsigned STARTUP_TIME_MS = 500;
  localparam int unsigned STARTUP_CYC     = STARTUP_TIME_MS * CYC_PER_MS;
  // Off-time granted per table code step
  localparam int unsigned OFF_STEP_US     = 20;
  localparam int unsigned OFF_STEP_CYC    = OFF_STEP_US * CYC_PER_US;
  // Interval between temperature conversions
  localparam int unsigned SAMPLE_TIME_US  = 1000;
  localparam int unsigned SAMPLE_CYC      = SAMPLE_TIME_US * CYC_PER_US;
  // Motor-lock tone, frequency and high share in percent
  localparam int unsigned LOCK_TONE_HZ    = 350;
  localparam int unsigned LOCK_TONE_PCT   = 15;
  localparam int unsigned LOCK_TONE_CYC   = CLK_HZ / LOCK_TONE_HZ;
  localparam int unsigned LOCK_HIGH_CYC   = LOCK_TONE_CYC * LOCK_TONE_PCT / 100;
  // Over-temperature tone, frequency and high share in percent
  localparam int unsigned OT_TONE_HZ      = 770;
  localparam int unsigned OT_TONE_PCT     = 13;
  localparam int unsigned OT_TONE_CYC     = CLK_HZ / OT_TONE_HZ;
  localparam int unsigned OT_HIGH_CYC     = OT_TONE_CYC * OT_TONE_PCT / 100;
  // Default over-temperature code, near 60 degrees
  localparam logic [7:0]  THERMAL_LIMIT   = 8'h80;
  // Reset value of the sampled temperature
  localparam logic [7:0]  TEMP_RESET      = 8'h00;
  // Table reset profile: code = top minus temperature
  localparam logic [7:0]  LUT_TOP         = 8'hff;
  // Operating modes
  typedef enum logic [1:0] {HFSC_START, HFSC_RUN, HFSC_LOCK} hfsc_mode_e;
endpackage : hfsc_pkg

// ===== design/hfsc_top.sv
// Hall-commutated two-coil fan speed controller with lock and thermal alarms
//
// Overview of operation
// - Coil A starts on each Hall fall
// - Coil B starts on each Hall rise
// - Falling edge detected edge-sensitively
// - Rising edge captured edge-sensitively
// - Full speed means zero off-time
// - Slower speed lengthens off, shortens on
// - Off-time follows thermal reading
// - Writable table maps temperature to speed
// - Temperature from 8-bit conversion
// - Lock after over 100ms without edges
// - Lock stops both coils at once
// - Lock then raises the alarm
// - Lock tone 350Hz, 15% high
// - Over-temperature tone 770Hz, 13% high
// - Start-up at full power, then thermal
// - Lock is final until reset
// - Over-temperature alarms, motor keeps running
`timescale 1ns/1ps
module hfsc_top #(
  parameter int unsigned LOCK_CYC      = hfsc_pkg::LOCK_CYC,
  parameter int unsigned STARTUP_CYC   = hfsc_pkg::STARTUP_CYC,
  parameter int unsigned SAMPLE_CYC    = hfsc_pkg::SAMPLE_CYC,
  parameter int unsigned LOCK_TONE_CYC = hfsc_pkg::LOCK_TONE_CYC,
  parameter int unsigned LOCK_HIGH_CYC = hfsc_pkg::LOCK_HIGH_CYC,
  parameter int unsigned OT_TONE_CYC   = hfsc_pkg::OT_TONE_CYC,
  parameter int unsigned OT_HIGH_CYC   = hfsc_pkg::OT_HIGH_CYC,
  parameter logic [7:0]  THERMAL_LIMIT = hfsc_pkg::THERMAL_LIMIT
) (
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  input  wire logic       hall_in,
  input  wire logic [7:0] adc_data,
  input  wire logic       adc_valid,
  input  wire logic       lut_wr_en,
  input  wire logic [7:0] lut_wr_addr,
  input  wire logic [7:0] lut_wr_data,
  output logic            coil_drive_a,
  output logic            coil_drive_b,
  output logic            alarm_switch,
  output logic            adc_start,
  output logic            motor_locked,
  output logic            over_temp
);
  localparam int unsigned W = hfsc_pkg::CNT_W;

  // Refuse timer values the counters cannot hold
  if (LOCK_CYC + 2 >= (1 << W) || STARTUP_CYC >= (1 << W) || SAMPLE_CYC < 2 ||
      SAMPLE_CYC >= (1 << W) || LOCK_TONE_CYC >= (1 << W) || OT_TONE_CYC >= (1 << W) ||
      LOCK_HIGH_CYC >= LOCK_TONE_CYC || OT_HIGH_CYC >= OT_TONE_CYC || LOCK_CYC < 1)
  begin : g_bad_param
    $error("hfsc_top: timer parameter out of range");
  end

  // Off-time in clock cycles for a table code
  function automatic logic [W-1:0] off_cycles(input logic [7:0] code);
    off_cycles = W'(code) * W'(hfsc_pkg::OFF_STEP_CYC);
  endfunction : off_cycles

  // Registered state
  hfsc_pkg::hfsc_mode_e mode_ff,      nxt_mode;       // Operating mode
  logic                 hall_prev_ff, nxt_hall_prev;  // Last Hall level
  logic [W-1:0]         off_cnt_ff,   nxt_off_cnt;    // Remaining off-time
  logic [W-1:0]         lock_cnt_ff,  nxt_lock_cnt;   // Cycles since last edge
  logic [W-1:0]         start_cnt_ff, nxt_start_cnt;  // Start-up elapsed
  logic [W-1:0]         samp_cnt_ff,  nxt_samp_cnt;   // Conversion pacing
  logic [W-1:0]         tone_cnt_ff,  nxt_tone_cnt;   // Position in tone period
  logic [7:0]           temp_ff,      nxt_temp;       // Latest temperature
  logic                 drive_a_ff,   nxt_drive_a;    // Coil A switch
  logic                 drive_b_ff,   nxt_drive_b;    // Coil B switch
  logic                 alarm_ff,     nxt_alarm;      // Alarm switch
  logic                 adc_start_ff, nxt_adc_start;  // Conversion request
  logic                 locked_ff,    nxt_locked;     // Lock status
  logic                 ot_ff,        nxt_ot;         // Over-temperature status
  logic [7:0]           lut_mem [256];                // Temperature to off-code table

  // Combinational helpers
  logic                 hall_fall;   // Hall went high to low
  logic                 hall_rise;   // Hall went low to high
  logic                 hall_edge;   // Either edge
  logic [W-1:0]         tone_per;    // Active tone period
  logic [W-1:0]         tone_high;   // Active tone high time
  logic                 tone_on;     // A tone is requested

  // Edge detection on the synchronous Hall level
  always_comb
  begin
    hall_fall = hall_prev_ff & ~hall_in;
    hall_rise = ~hall_prev_ff & hall_in;
    hall_edge = hall_fall | hall_rise;
  end

  // Temperature-to-speed table; writable from the user port
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      // Linear default profile: hotter means shorter off-time
      for (int i = 0; i < 256; i++)
      begin
        lut_mem[i] <= hfsc_pkg::LUT_TOP - 8'(i);
      end
    end
    else if (lut_wr_en)
    begin
      lut_mem[lut_wr_addr] <= lut_wr_data;
    end
  end

  // Mode, timers and coil drives
  always_comb
  begin
    nxt_mode      = mode_ff;
    nxt_hall_prev = hall_in;
    nxt_start_cnt = start_cnt_ff;
    // Outside lock mode the lock timer restarts on any edge, otherwise counts up
    if (mode_ff == hfsc_pkg::HFSC_LOCK)
    begin
      nxt_lock_cnt = lock_cnt_ff;  // Edges are ignored once locked
    end
    else if (hall_edge)
    begin
      nxt_lock_cnt = '0;
    end
    else
    begin
      nxt_lock_cnt = lock_cnt_ff + W'(1);
    end
    // Off-time reloads from the table at each commutation edge in run mode, clears at edges in other modes, and counts down
    if (hall_edge && mode_ff == hfsc_pkg::HFSC_RUN)
    begin
      nxt_off_cnt = off_cycles(lut_mem[temp_ff]);
    end
    else if (hall_edge)
    begin
      nxt_off_cnt = '0;
    end
    else if (off_cnt_ff != '0)
    begin
      nxt_off_cnt = off_cnt_ff - W'(1);
    end
    else
    begin
      nxt_off_cnt = '0;
    end
    unique case (mode_ff)
      hfsc_pkg::HFSC_START:
      begin
        // Full power until the start-up period ends
        nxt_start_cnt = start_cnt_ff + W'(1);
        if (start_cnt_ff == W'(STARTUP_CYC - 1))
        begin
          nxt_mode = hfsc_pkg::HFSC_RUN;
        end
      end
      hfsc_pkg::HFSC_RUN:
      begin
        nxt_mode = hfsc_pkg::HFSC_RUN;
      end
      hfsc_pkg::HFSC_LOCK:
      begin
        nxt_mode = hfsc_pkg::HFSC_LOCK;
      end
    endcase
    // No edge for longer than the lock window
    if (mode_ff != hfsc_pkg::HFSC_LOCK && lock_cnt_ff > W'(LOCK_CYC))
    begin
      nxt_mode = hfsc_pkg::HFSC_LOCK;
    end
    // Coil A owns the low Hall half, coil B the high half
    nxt_drive_a = (nxt_mode != hfsc_pkg::HFSC_LOCK) && ~hall_in && (nxt_off_cnt == '0);
    nxt_drive_b = (nxt_mode != hfsc_pkg::HFSC_LOCK) && hall_in && (nxt_off_cnt == '0);
    nxt_locked  = (nxt_mode == hfsc_pkg::HFSC_LOCK);
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mode_ff      <= hfsc_pkg::HFSC_START;
      hall_prev_ff <= 1'b0;
      off_cnt_ff   <= '0;
      lock_cnt_ff  <= '0;
      start_cnt_ff <= '0;
      drive_a_ff   <= 1'b0;
      drive_b_ff   <= 1'b0;
      locked_ff    <= 1'b0;
    end
    else
    begin
      mode_ff      <= nxt_mode;
      hall_prev_ff <= nxt_hall_prev;
      off_cnt_ff   <= nxt_off_cnt;
      lock_cnt_ff  <= nxt_lock_cnt;
      start_cnt_ff <= nxt_start_cnt;
      drive_a_ff   <= nxt_drive_a;
      drive_b_ff   <= nxt_drive_b;
      locked_ff    <= nxt_locked;
    end
  end

  // Periodic conversion request and temperature capture
  always_comb
  begin
    if (samp_cnt_ff == W'(SAMPLE_CYC - 1))
    begin
      nxt_samp_cnt  = '0;
      nxt_adc_start = 1'b1;
    end
    else
    begin
      nxt_samp_cnt  = samp_cnt_ff + W'(1);
      nxt_adc_start = 1'b0;
    end
    nxt_temp = adc_valid ? adc_data : temp_ff;
    nxt_ot   = (temp_ff >= THERMAL_LIMIT);
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      samp_cnt_ff  <= '0;
      adc_start_ff <= 1'b0;
      temp_ff      <= hfsc_pkg::TEMP_RESET;
      ot_ff        <= 1'b0;
    end
    else
    begin
      samp_cnt_ff  <= nxt_samp_cnt;
      adc_start_ff <= nxt_adc_start;
      temp_ff      <= nxt_temp;
      ot_ff        <= nxt_ot;
    end
  end

  // Alarm tone: lock tone wins over the over-temperature tone
  always_comb
  begin
    if (mode_ff == hfsc_pkg::HFSC_LOCK)
    begin
      tone_per  = W'(LOCK_TONE_CYC);
      tone_high = W'(LOCK_HIGH_CYC);
    end
    else
    begin
      tone_per  = W'(OT_TONE_CYC);
      tone_high = W'(OT_HIGH_CYC);
    end
    tone_on = (mode_ff == hfsc_pkg::HFSC_LOCK) || ot_ff;
    // Counter wraps at the period; out-of-range count after a tone swap restarts
    if (tone_on && tone_cnt_ff < tone_per - W'(1))
    begin
      nxt_tone_cnt = tone_cnt_ff + W'(1);
    end
    else
    begin
      nxt_tone_cnt = '0;
    end
    nxt_alarm = tone_on && (tone_cnt_ff < tone_high);
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tone_cnt_ff <= '0;
      alarm_ff    <= 1'b0;
    end
    else
    begin
      tone_cnt_ff <= nxt_tone_cnt;
      alarm_ff    <= nxt_alarm;
    end
  end

  // Outputs straight from flip-flops
  assign coil_drive_a = drive_a_ff;
  assign coil_drive_b = drive_b_ff;
  assign alarm_switch = alarm_ff;
  assign adc_start    = adc_start_ff;
  assign motor_locked = locked_ff;
  assign over_temp    = ot_ff;

  // Checks
  a_fall_drives_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (hall_fall && mode_ff == hfsc_pkg::HFSC_START && lock_cnt_ff <= W'(LOCK_CYC)) |=> (coil_drive_a && !coil_drive_b))
    else $error("coil A not driven after Hall fall at start-up");
  a_rise_drives_b: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (hall_rise && mode_ff == hfsc_pkg::HFSC_START && lock_cnt_ff <= W'(LOCK_CYC)) |=> (coil_drive_b && !coil_drive_a))
    else $error("coil B not driven after Hall rise at start-up");
  a_off_holds: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (off_cnt_ff != '0) |-> (!coil_drive_a && !coil_drive_b))
    else $error("coil driven during off-time");
  a_off_loads: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (hall_edge && mode_ff == hfsc_pkg::HFSC_RUN) |=> (off_cnt_ff == off_cycles(lut_mem[$past(temp_ff)])))
    else $error("off-time not loaded from table");
  a_lock_entry: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (mode_ff != hfsc_pkg::HFSC_LOCK && lock_cnt_ff == W'(LOCK_CYC + 1)) |=> (motor_locked && !coil_drive_a && !coil_drive_b))
    else $error("lock not declared after window");
  a_lock_stops: assert property (@(posedge sys_clk) disable iff (sys_rst)
    motor_locked |-> (!coil_drive_a && !coil_drive_b))
    else $error("coil driven while locked");
  a_lock_final: assert property (@(posedge sys_clk) disable iff (sys_rst)
    motor_locked |=> (motor_locked && $stable(lock_cnt_ff)))
    else $error("lock left without reset");
  a_edge_restart: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (hall_edge && mode_ff != hfsc_pkg::HFSC_LOCK) |=> (lock_cnt_ff == '0))
    else $error("lock timer not restarted by edge");
  a_lock_tone: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (mode_ff == hfsc_pkg::HFSC_LOCK && tone_cnt_ff == W'(LOCK_HIGH_CYC)) |=> (!alarm_switch ##1 !alarm_switch))
    else $error("lock tone high time wrong");
  a_tone_start: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (tone_on && tone_cnt_ff == '0) |=> alarm_switch)
    else $error("alarm not raised at tone start");
  a_ot_period: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (mode_ff != hfsc_pkg::HFSC_LOCK && ot_ff && tone_cnt_ff == W'(OT_TONE_CYC - 1)) |=> (tone_cnt_ff == '0))
    else $error("over-temperature tone period wrong");
  a_start_end: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (mode_ff == hfsc_pkg::HFSC_START && start_cnt_ff == W'(STARTUP_CYC - 1) && lock_cnt_ff <= W'(LOCK_CYC))
      |=> (mode_ff == hfsc_pkg::HFSC_RUN))
    else $error("start-up did not end on time");
endmodule : hfsc_top

// ===== verification/hfsc_fan_model.sv
// Hall sensor and thermal sensor model standing at the fan controller's pins
`timescale 1ns/1ps
module hfsc_fan_model #(
  parameter int HALF_PER = 1500            // Cycles per Hall half turn
) (
  input  wire logic       sys_clk,         // System clock
  input  wire logic       hall_en,         // Rotor turns while high, stalls while low
  input  wire logic [7:0] temp_code,       // Temperature the sensor reports
  input  wire logic       adc_start,       // Conversion request from the controller
  output logic            hall_in,         // Hall sensor level
  output logic            adc_valid,       // Conversion result strobe
  output logic [7:0]      adc_data         // Conversion result
);
  int         hall_cnt;                    // Cycles into the current half turn
  logic [2:0] conv_dly;                    // Conversion latency pipeline

  initial
  begin
    hall_in   = 1'b0;
    adc_valid = 1'b0;
    adc_data  = 8'h00;
    hall_cnt  = 0;
    conv_dly  = 3'h0;
  end

  // Rotor: toggles the Hall level each half turn, holds its level when stalled
  always @(negedge sys_clk)
  begin
    if (hall_en)
    begin
      hall_cnt <= (hall_cnt >= HALF_PER - 1) ? 0 : hall_cnt + 1;
      if (hall_cnt >= HALF_PER - 1)
        hall_in <= ~hall_in;
    end
  end

  // Converter: 8-bit result three cycles after a request, line wanders otherwise
  always @(negedge sys_clk)
  begin
    conv_dly  <= {conv_dly[1:0], adc_start};
    adc_valid <= conv_dly[2];
    adc_data  <= conv_dly[2] ? temp_code : ~adc_data;
  end
endmodule : hfsc_fan_model

// ===== verification/tb_hfsc_top.sv
// Self-checking bench for the fan speed controller
`timescale 1ns/1ps
`define CHK(what, exp, got) begin compares++; if ((got) !== (exp)) begin error_cnt++; \
  $display("unexpected %s: expected %0d seen %0d", what, exp, got); end end
module tb_hfsc_top;
  localparam int LOCK_N = 4000;            // Shortened lock window
  localparam int HALF_N = 1500;            // Hall half turn in cycles
  localparam int START_N = 3500;           // Start-up spans the first rise and fall
  localparam int SAMP_N = 20;              // Conversion request spacing
  localparam int LT_PER = 20;              // Lock tone period
  localparam int LT_HI = 3;                // Lock tone high time
  localparam int OT_PER = 10;              // Over-temperature tone period
  localparam int OT_HI = 1;                // Over-temperature tone high time
  localparam logic [7:0] LIMIT = 8'h80;    // Over-temperature code
  logic       sys_clk, sys_rst, hall_in, adc_valid, lut_wr_en, hall_en, adc_start; // Bench and pin signals
  logic       coil_drive_a, coil_drive_b, alarm_switch, motor_locked, over_temp;   // Controller outputs
  logic [7:0] adc_data, lut_wr_addr, lut_wr_data, temp_code, t, c;                 // Codes
  int         error_cnt = 0, compares = 0, seed = 20, n, hi;                      // Counters and results

  // Controller with shortened counts
  hfsc_top #(.LOCK_CYC(LOCK_N), .STARTUP_CYC(START_N), .SAMPLE_CYC(SAMP_N), .LOCK_TONE_CYC(LT_PER),
    .LOCK_HIGH_CYC(LT_HI), .OT_TONE_CYC(OT_PER), .OT_HIGH_CYC(OT_HI), .THERMAL_LIMIT(LIMIT))
    u_hfsc_top (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .hall_in(hall_in), .adc_data(adc_data), .adc_valid(adc_valid), .lut_wr_en(lut_wr_en),
    .lut_wr_addr(lut_wr_addr), .lut_wr_data(lut_wr_data), .coil_drive_a(coil_drive_a),
    .coil_drive_b(coil_drive_b), .alarm_switch(alarm_switch), .adc_start(adc_start),
    .motor_locked(motor_locked), .over_temp(over_temp));

  // Rotor and thermal sensor
  hfsc_fan_model #(.HALF_PER(HALF_N)) u_hfsc_fan_model (.sys_clk(sys_clk), .hall_en(hall_en),
    .temp_code(temp_code), .adc_start(adc_start), .hall_in(hall_in), .adc_valid(adc_valid), .adc_data(adc_data));

  // 20 MHz clock
  always #25 sys_clk = ~sys_clk;

  // Expected high cycles of a tone over a whole number of periods
  function automatic int tone_highs(input int span, input int per, input int high);
    tone_highs = (span / per) * high;
  endfunction : tone_highs

  // Expected off-time in cycles for a table code
  function automatic int exp_off(input logic [7:0] code);
    exp_off = int'(code) * int'(hfsc_pkg::OFF_STEP_CYC);
  endfunction : exp_off

  // Writes one table entry with a single strobe
  task automatic lut_write(input logic [7:0] addr, input logic [7:0] data);
    begin
      lut_wr_addr = addr;
      lut_wr_data = data;
      lut_wr_en   = 1'b1;
      @(negedge sys_clk);
      lut_wr_en   = 1'b0;
    end
  endtask : lut_write

  // Cycles from a Hall edge of the given level until its coil turns on
  task automatic off_time(input logic pol, output int cnt);
    logic own;
    begin
      cnt = 0;
      @(hall_in iff hall_in === pol);
      @(posedge sys_clk);
      @(negedge sys_clk);
      own = pol ? coil_drive_b : coil_drive_a;
      while (own !== 1'b1 && cnt < 5000)
      begin
        `CHK("idle_coils", 1'b0, coil_drive_a | coil_drive_b)
        cnt++;
        @(negedge sys_clk);
        own = pol ? coil_drive_b : coil_drive_a;
      end
      `CHK("other_coil", 1'b0, pol ? coil_drive_a : coil_drive_b)
    end
  endtask : off_time

  // Counts the cycles in which the alarm switch is on
  task automatic count_high(input int span, output int cnt);
    begin
      cnt = 0;
      repeat (span)
      begin
        @(negedge sys_clk);
        cnt += (alarm_switch === 1'b1);
      end
    end
  endtask : count_high

  // Prints the counts and the verdict, then ends the run
  task automatic final_report;
    begin
      $display("compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask : final_report

  // Main sequence
  initial
  begin
    sys_clk = 1'b0;
    sys_rst = 1'b1;
    lut_wr_en = 1'b0;
    lut_wr_addr = 8'h00;
    lut_wr_data = 8'h00;
    hall_en = 1'b0;
    temp_code = 8'h00;
    repeat (12) @(negedge sys_clk);
    sys_rst = 1'b0;
    repeat (3) @(negedge sys_clk);
    `CHK("coil_drive_a", 1'b1, coil_drive_a)
    `CHK("coil_drive_b", 1'b0, coil_drive_b)
    // Conversion requests come at a fixed spacing
    n = 0;
    repeat (100)
    begin
      @(negedge sys_clk);
      n += (adc_start === 1'b1);
    end
    `CHK("adc_start_pulses", 100 / SAMP_N, n)
    hall_en = 1'b1;
    // Both commutation edges fall inside start-up: no off-time yet
    for (int p = 1; p >= 0; p--)
    begin
      off_time(p[0], n);
      `CHK("startup_off", 0, n)
    end
    $display("test startup done");
    repeat (START_N - 2 * HALF_N + 100) @(negedge sys_clk);
    // Corners first: full speed just below the limit, then slowest at the limit
    for (int i = 0; i < 6; i++)
    begin
      t = (i == 0) ? 8'h7f : (i == 1) ? 8'h80 : 8'($random(seed)) & 8'h7f;
      c = (i == 0) ? 8'h00 : (i == 1) ? 8'h03 : 8'h01 + 8'($unsigned($random(seed)) % 3);
      lut_write(t, c);
      temp_code = t;
      repeat (60) @(negedge sys_clk);
      `CHK("over_temp", (t >= LIMIT), over_temp)
      for (int p = 0; p < 2; p++)
      begin
        off_time(p[0], n);
        `CHK("off_cycles", exp_off(c), n)
      end
      count_high(100, hi);
      `CHK("alarm_high", (t >= LIMIT) ? tone_highs(100, OT_PER, OT_HI) : 0, hi)
      `CHK("motor_locked", 1'b0, motor_locked)
      $display("test speed %0d done", i);
    end
    // Stall the rotor just after an edge, over-temperature held meanwhile
    temp_code = 8'h90;
    @(hall_in);
    @(posedge sys_clk);
    @(negedge sys_clk);
    hall_en = 1'b0;
    n = 0;
    while (motor_locked !== 1'b1 && n < 2 * LOCK_N)
    begin
      n++;
      @(negedge sys_clk);
    end
    `CHK("lock_cycles", LOCK_N + 2, n)
    `CHK("coils_at_lock", 1'b0, coil_drive_a | coil_drive_b)
    count_high(200, hi);
    `CHK("lock_alarm_high", tone_highs(200, LT_PER, LT_HI), hi)
    hall_en = 1'b1;
    repeat (2 * HALF_N)
    begin
      @(negedge sys_clk);
      `CHK("coils_locked", 1'b0, coil_drive_a | coil_drive_b)
    end
    `CHK("lock_sticky", 1'b1, motor_locked)
    $display("test lock done");
    final_report();
  end

  // Watchdog well beyond the expected run length
  initial
  begin
    repeat (100000) @(posedge sys_clk);
    error_cnt++;
    $display("unexpected watchdog: expected 0 seen 1");
    final_report();
  end
endmodule : tb_hfsc_top
